// file: hw/lgr_pkg.sv
// shared constants for the single-wire logger front end
package lgr_pkg;
	// --------------------------------------------------------------
	// clock and counter widths
	// --------------------------------------------------------------
	localparam int CLK_NS = 10;
	localparam int LOW_W = 17;
	localparam int DLY_W = 28;
	localparam int NS_PER_MS = 1000000;

	// --------------------------------------------------------------
	// slot timing in ns, command delays in ms
	// --------------------------------------------------------------
	localparam int T_RST_STD_NS = 480000;
	localparam int T_RST_OD_NS = 48000;
	// decision point between one_bit_low_time max and zero_bit_low_time min
	localparam int T_SAMPLE_STD_NS = 30000;
	localparam int T_SAMPLE_OD_NS = 3000;
	// zero hold outlasts the master_read_sample_time limit
	localparam int T_HOLD_STD_NS = 30000;
	localparam int T_HOLD_OD_NS = 3000;
	localparam int T_PWAIT_STD_NS = 30000;
	localparam int T_PWAIT_OD_NS = 3000;
	localparam int T_PLOW_STD_NS = 120000;
	localparam int T_PLOW_OD_NS = 12000;
	localparam int T_LOG_CLEAR_MS = 1500;
	localparam int T_CLOCK_START_MS = 500;

	// --------------------------------------------------------------
	// cycle counts: slot times round up, ms delays convert exactly
	// --------------------------------------------------------------
	localparam int RST_STD_CYC = (T_RST_STD_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_OD_CYC = (T_RST_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int SAMPLE_STD_CYC = (T_SAMPLE_STD_NS + CLK_NS - 1) / CLK_NS;
	localparam int SAMPLE_OD_CYC = (T_SAMPLE_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_STD_CYC = (T_HOLD_STD_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_OD_CYC = (T_HOLD_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PWAIT_STD_CYC = (T_PWAIT_STD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PWAIT_OD_CYC = (T_PWAIT_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PLOW_STD_CYC = (T_PLOW_STD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PLOW_OD_CYC = (T_PLOW_OD_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOG_CLEAR_CYC = T_LOG_CLEAR_MS * (NS_PER_MS / CLK_NS);
	localparam int CLOCK_START_CYC = T_CLOCK_START_MS * (NS_PER_MS / CLK_NS);

	// --------------------------------------------------------------
	// linear address space
	// --------------------------------------------------------------
	localparam int ADDR_W = 17;
	localparam int ADDR_BITS = 24;
	localparam int SCRATCH_BITS = 256;
	localparam logic [ADDR_W-1:0] GP_END = 17'h001ff;
	localparam logic [ADDR_W-1:0] REG_BASE = 17'h00200;
	localparam logic [ADDR_W-1:0] REG_END = 17'h0023f;
	localparam logic [ADDR_W-1:0] RO_BASE = 17'h00220;
	localparam logic [ADDR_W-1:0] RO_END = 17'h0022f;
	localparam logic [ADDR_W-1:0] PW_BASE = 17'h00230;
	localparam logic [ADDR_W-1:0] PW_END = 17'h0023f;
	localparam logic [ADDR_W-1:0] LOG_BASE = 17'h01000;
	localparam logic [ADDR_W-1:0] LOG_END = 17'h1f9ff;
	localparam logic [7:0] PW_READ_VAL = 8'h00;

	// --------------------------------------------------------------
	// command codes and result bytes
	// --------------------------------------------------------------
	localparam logic [7:0] ROM_READ = 8'h33;
	localparam logic [7:0] ROM_MATCH = 8'h55;
	localparam logic [7:0] ROM_SEARCH = 8'hf0;
	localparam logic [7:0] ROM_COND = 8'hec;
	localparam logic [7:0] ROM_SKIP = 8'hcc;
	localparam logic [7:0] ROM_OD_SKIP = 8'h3c;
	localparam logic [7:0] ROM_OD_MATCH = 8'h69;
	localparam logic [7:0] ROM_RESUME = 8'ha5;
	localparam logic [7:0] FN_WRITE = 8'h0f;
	localparam logic [7:0] FN_READ = 8'hf0;
	localparam logic [7:0] FN_LOG_CLEAR = 8'h96;
	localparam logic [7:0] FN_CLOCK_START = 8'h99;
	localparam logic [7:0] RES_BUSY = 8'hff;
	localparam logic [7:0] RES_OK = 8'haa;
endpackage

// file: hw/lgr_crc8.sv
// check byte over the low 56 bits of the identification code
`timescale 1ns/100ps
module lgr_crc8 (
	input wire logic [55:0] data_in,
	output logic [7:0] crc_out
);
	// --------------------------------------------------------------
	// x^8 + x^5 + x^4 + 1, shifted in lsb first from zero
	// --------------------------------------------------------------
	always_comb
	begin
		logic [7:0] c;
		logic fb;
		c = 8'h00;
		fb = 1'b0;
		for (int i = 0; i < 56; i++)
		begin
			fb = c[0] ^ data_in[i];
			c = {1'b0, c[7:1]};
			if (fb)
			begin
				c = c ^ 8'h8c;
			end
		end
		crc_out = c;
	end
endmodule

// file: hw/lgr_front_end.sv
// single-wire slot engine, network selection and memory command front end
//
// Contract
// R1: master writes a one with a short low pulse, 5 to 15 us, or 0.25 to 2 us.
// R2: master writes a zero holding low 60 to 120 us, or 6 to 16 us.
// R3: master samples a read slot within 15 us, or 2 us, of its falling edge.
// R4: log clear finishes within 1500 ms; result shows busy until then.
// R5: first clock start out of the clear state adds up to 500 ms.
// R6: storage holds scratchpad, general memory, two register pages and the data log.
// R7: everything but the id code and scratchpad sits in one linear address space.
// R8: data log, counters and some registers refuse master writes.
// R9: register pages refuse writes while a mission is programmed.
// R10: two passwords are write only; reads never return them.
// R11: after reset the master first sends one of eight selection commands.
// R12: an overdrive selection byte at standard speed switches to overdrive timing.
// R13: memory and control commands are taken only after successful selection.
// R14: every byte on the wire moves least significant bit first.
// R15: id code is family byte, 48-bit serial and check byte over 56 bits.
// R16: device starts in the clear state and returns to it after a log clear.
// R17: a standard-length reset pulse while in overdrive restores standard speed.
// R18: the line is left alone unless selection has addressed the device; the code still drives presence pulses and ROM read and search replies.
`timescale 1ns/100ps
module lgr_front_end
	import lgr_pkg::*;
#(
	parameter int RST_STD = RST_STD_CYC,
	parameter int RST_OD = RST_OD_CYC,
	parameter int PLOW_STD = PLOW_STD_CYC,
	parameter int LOG_CLEAR = LOG_CLEAR_CYC,
	parameter int CLOCK_START = CLOCK_START_CYC,
	parameter logic [7:0] FAMILY = 8'h5a, // arbitrary value
	parameter logic [47:0] SERIAL = 48'h0000_0000_0001 // arbitrary value
)(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic io_in,
	output logic io_out,
	output logic io_oe_out,
	input wire logic mission_in,
	input wire logic alarm_in,
	input wire logic [7:0] mem_rdata_in,
	output logic [ADDR_W-1:0] mem_addr_out,
	output logic mem_we_out,
	output logic [7:0] mem_wdata_out,
	output logic overdrive_out,
	output logic selected_out,
	output logic busy_out,
	output logic clear_state_out,
	output logic clock_run_out
);
	// --------------------------------------------------------------
	// parameter checks
	// --------------------------------------------------------------
	if (RST_OD >= RST_STD || RST_STD >= (1 << LOW_W) || PLOW_STD >= (1 << LOW_W))
	begin : g_bad_slot
		$error("slot counts do not fit the low counter");
	end
	if (LOG_CLEAR < 1 || CLOCK_START < 1 || LOG_CLEAR >= (1 << DLY_W) || CLOCK_START >= (1 << DLY_W))
	begin : g_bad_dly
		$error("delay counts do not fit the delay counter");
	end

	typedef enum logic [1:0] {SL_IDLE, SL_LOW, SL_PWAIT, SL_PLOW} lgr_slot_t;
	typedef enum logic [3:0] {P_IDLE, P_ROMCMD, P_ROMREAD, P_MATCH, P_SEARCH, P_FUNC, P_ADDR, P_WRITE, P_READ,
		P_RESULT} lgr_proto_t;
	typedef enum logic [1:0] {PD_NONE, PD_CLEAR, PD_CLOCK} lgr_pend_t;

	function automatic logic in_rng(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
		input logic [ADDR_W-1:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	function automatic logic wr_ok(input logic [ADDR_W-1:0] a, input logic mission);
		wr_ok = (a <= GP_END) || (in_rng(a, REG_BASE, REG_END) && !mission && !in_rng(a, RO_BASE, RO_END)); // [R6]
	endfunction

	// --------------------------------------------------------------
	// identification code
	// --------------------------------------------------------------
	logic [7:0] rom_crc;
	logic [63:0] rom;
	lgr_crc8 u_crc (
		.data_in({SERIAL, FAMILY}),
		.crc_out(rom_crc)
	);
	assign rom = {rom_crc, SERIAL, FAMILY}; // [R15]

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	// --------------------------------------------------------------
	// slot engine
	// --------------------------------------------------------------
	logic io_meta, io_sync, io_prev;
	lgr_slot_t slot, next_slot;
	logic [LOW_W-1:0] low_cnt, next_low_cnt;
	logic drv, next_drv, next_oe;
	logic bit_evt, next_bit_evt, bit_val, next_bit_val;
	logic rst_evt, next_rst_evt, rst_long, next_rst_long;
	logic od, tx_en, tx_bit;
	logic [LOW_W-1:0] th_rst, th_sample, th_hold, th_pwait, th_plow;

	assign th_rst = od ? LOW_W'(RST_OD) : LOW_W'(RST_STD);
	assign th_sample = od ? LOW_W'(SAMPLE_OD_CYC) : LOW_W'(SAMPLE_STD_CYC);
	assign th_hold = od ? LOW_W'(HOLD_OD_CYC) : LOW_W'(HOLD_STD_CYC);
	assign th_pwait = od ? LOW_W'(PWAIT_OD_CYC) : LOW_W'(PWAIT_STD_CYC);
	assign th_plow = od ? LOW_W'(PLOW_OD_CYC) : LOW_W'(PLOW_STD);

	always_comb
	begin
		next_slot = slot;
		next_low_cnt = low_cnt;
		next_drv = drv;
		next_oe = 1'b0;
		next_bit_evt = 1'b0;
		next_bit_val = bit_val;
		next_rst_evt = 1'b0;
		next_rst_long = rst_long;
		unique case (slot)
			SL_IDLE:
				if (io_prev && !io_sync)
				begin
					next_slot = SL_LOW;
					next_low_cnt = LOW_W'(1);
					next_drv = tx_en && !tx_bit; // [R3] [R18]
					next_oe = next_drv;
				end
			SL_LOW:
			begin
				if (low_cnt != '1)
				begin
					next_low_cnt = low_cnt + LOW_W'(1);
				end
				next_oe = drv && (low_cnt < th_hold);
				if (io_sync)
				begin
					next_slot = SL_IDLE;
					next_oe = 1'b0;
					if (low_cnt >= th_rst)
					begin
						next_rst_evt = 1'b1;
						next_rst_long = low_cnt >= LOW_W'(RST_STD); // [R17]
						next_slot = SL_PWAIT;
						next_low_cnt = '0;
					end
					else
					begin
						// short pulse reads as one, long as zero
						next_bit_evt = 1'b1;
						next_bit_val = low_cnt < th_sample; // [R1] [R2]
					end
				end
			end
			SL_PWAIT:
			begin
				next_low_cnt = low_cnt + LOW_W'(1);
				if (low_cnt >= th_pwait)
				begin
					next_slot = SL_PLOW;
					next_low_cnt = '0;
					next_oe = 1'b1;
				end
			end
			SL_PLOW:
			begin
				next_low_cnt = low_cnt + LOW_W'(1);
				next_oe = low_cnt < th_plow;
				if (low_cnt >= th_plow)
				begin
					next_slot = SL_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			io_meta <= 1'b1;
			io_sync <= 1'b1;
			io_prev <= 1'b1;
			slot <= SL_IDLE;
			low_cnt <= '0;
			drv <= 1'b0;
			io_oe_out <= 1'b0;
			io_out <= 1'b0;
			bit_evt <= 1'b0;
			bit_val <= 1'b0;
			rst_evt <= 1'b0;
			rst_long <= 1'b0;
		end
		else
		begin
			io_meta <= io_in;
			io_sync <= io_meta;
			io_prev <= io_sync;
			slot <= next_slot;
			low_cnt <= next_low_cnt;
			drv <= next_drv;
			io_oe_out <= next_oe;
			io_out <= 1'b0;
			bit_evt <= next_bit_evt;
			bit_val <= next_bit_val;
			rst_evt <= next_rst_evt;
			rst_long <= next_rst_long;
		end
	end

	sequence s_reset_end;
		rst_evt;
	endsequence
	sequence s_quiet;
		(slot == SL_PWAIT && !io_oe_out) [*3];
	endsequence
	property p_presence_gap;
		s_reset_end |=> s_quiet;
	endproperty
	a_presence_gap: assert property (p_presence_gap) else $error("line driven right after reset"); // [R18]

	// --------------------------------------------------------------
	// protocol layer
	// --------------------------------------------------------------
	lgr_proto_t pst, next_pst;
	lgr_pend_t pend, next_pend;
	logic [5:0] bcnt, next_bcnt;
	logic [1:0] phase, next_phase;
	logic [7:0] shreg, next_shreg, txbyte, next_txbyte, sh_in, next_wdata;
	logic [ADDR_BITS-1:0] addr, next_addr;
	logic [DLY_W-1:0] dly_cnt, next_dly_cnt;
	logic rd_mode, next_rd_mode, selected, next_selected, resume_ok, next_resume_ok, next_od;
	logic load_pend, next_load_pend, next_we, next_clear_state, next_clock_run, byte_done;

	assign sh_in = {bit_val, shreg[7:1]}; // [R14]
	assign byte_done = bcnt[2:0] == 3'h7;
	assign mem_addr_out = addr[ADDR_W-1:0]; // [R7]

	always_comb
	begin
		tx_en = 1'b0;
		tx_bit = 1'b1;
		unique case (pst)
			P_ROMREAD:
			begin
				tx_en = 1'b1;
				tx_bit = rom[bcnt];
			end
			P_SEARCH:
			begin
				tx_en = phase != 2'h2;
				tx_bit = rom[bcnt] ^ phase[0];
			end
			P_READ, P_RESULT:
			begin
				tx_en = selected; // [R18]
				tx_bit = txbyte[bcnt[2:0]]; // [R14]
			end
			P_IDLE, P_ROMCMD, P_MATCH, P_FUNC, P_ADDR, P_WRITE: ;
		endcase
	end

	always_comb
	begin
		next_pst = pst;
		next_pend = pend;
		next_bcnt = bcnt;
		next_phase = phase;
		next_shreg = shreg;
		next_txbyte = txbyte;
		next_addr = addr;
		next_dly_cnt = dly_cnt;
		next_rd_mode = rd_mode;
		next_selected = selected;
		next_resume_ok = resume_ok;
		next_od = od;
		next_load_pend = 1'b0;
		next_we = 1'b0;
		next_wdata = mem_wdata_out;
		next_clear_state = clear_state_out;
		next_clock_run = clock_run_out;
		if (load_pend)
		begin
			// passwords never leave the device
			next_txbyte = in_rng(addr[ADDR_W-1:0], PW_BASE, PW_END) ? PW_READ_VAL : mem_rdata_in; // [R10]
		end
		if (mem_we_out)
		begin
			next_addr = addr + ADDR_BITS'(1);
		end
		if (dly_cnt != '0)
		begin
			next_dly_cnt = dly_cnt - DLY_W'(1);
			if (dly_cnt == DLY_W'(1))
			begin
				next_pend = PD_NONE;
				unique case (pend)
					PD_CLEAR:
					begin
						next_clear_state = 1'b1; // [R16]
						next_clock_run = 1'b0;
					end
					PD_CLOCK:
					begin
						next_clear_state = 1'b0; // [R5]
						next_clock_run = 1'b1;
					end
					PD_NONE: ;
				endcase
			end
		end
		if (rst_evt)
		begin
			next_pst = P_ROMCMD;
			next_bcnt = '0;
			next_phase = '0;
			next_selected = 1'b0;
			if (rst_long)
			begin
				next_od = 1'b0; // [R17]
			end
		end
		else if (bit_evt)
		begin
			next_shreg = sh_in;
			next_bcnt = bcnt + 6'h01;
			unique case (pst)
				P_IDLE: ;
				P_ROMCMD:
					if (byte_done)
					begin
						next_bcnt = '0;
						case (sh_in)
							ROM_READ: next_pst = P_ROMREAD;
							ROM_MATCH: next_pst = P_MATCH;
							ROM_SEARCH: next_pst = P_SEARCH;
							ROM_COND: next_pst = alarm_in ? P_SEARCH : P_IDLE;
							ROM_OD_MATCH:
							begin
								next_pst = P_MATCH;
								next_od = 1'b1; // [R12]
							end
							ROM_SKIP, ROM_OD_SKIP:
							begin
								next_pst = P_FUNC;
								next_selected = 1'b1;
								next_resume_ok = 1'b0;
								next_od = od | (sh_in == ROM_OD_SKIP); // [R12]
							end
							ROM_RESUME:
							begin
								next_pst = resume_ok ? P_FUNC : P_IDLE;
								next_selected = resume_ok;
							end
							default: next_pst = P_IDLE;
						endcase
					end
				P_ROMREAD:
					if (bcnt == 6'h3f)
					begin
						next_pst = P_FUNC;
						next_selected = 1'b1;
					end
				P_MATCH:
					if (bit_val != rom[bcnt])
					begin
						next_pst = P_IDLE;
					end
					else if (bcnt == 6'h3f)
					begin
						next_pst = P_FUNC;
						next_selected = 1'b1;
						next_resume_ok = 1'b1;
					end
				P_SEARCH:
					if (phase != 2'h2)
					begin
						next_bcnt = bcnt;
						next_phase = phase + 2'h1;
					end
					else
					begin
						next_phase = '0;
						if (bit_val != rom[bcnt])
						begin
							next_pst = P_IDLE;
						end
						else if (bcnt == 6'h3f)
						begin
							next_pst = P_FUNC;
							next_selected = 1'b1;
							next_resume_ok = 1'b1;
						end
					end
				P_FUNC:
					if (byte_done)
					begin
						// only reachable through a completed selection
						next_bcnt = '0;
						next_pst = P_RESULT; // [R13]
						next_txbyte = RES_BUSY;
						case (sh_in)
							FN_WRITE, FN_READ:
							begin
								next_pst = P_ADDR;
								next_rd_mode = sh_in == FN_READ;
							end
							FN_LOG_CLEAR:
							begin
								next_dly_cnt = DLY_W'(LOG_CLEAR); // [R4]
								next_pend = PD_CLEAR;
								next_clear_state = 1'b0;
								next_clock_run = 1'b0;
							end
							FN_CLOCK_START:
							begin
								next_dly_cnt = clear_state_out ? DLY_W'(CLOCK_START) : DLY_W'(1); // [R5] [R16]
								next_pend = PD_CLOCK;
							end
							default: next_pst = P_IDLE;
						endcase
					end
				P_ADDR:
				begin
					if (byte_done)
					begin
						next_addr = {sh_in, addr[ADDR_BITS-1:8]}; // [R14]
					end
					if (bcnt == 6'(ADDR_BITS - 1))
					begin
						next_bcnt = '0;
						next_pst = rd_mode ? P_READ : P_WRITE;
						next_load_pend = rd_mode;
					end
				end
				P_WRITE:
					if (byte_done)
					begin
						next_bcnt = '0;
						next_we = wr_ok(addr[ADDR_W-1:0], mission_in); // [R8] [R9]
						next_wdata = sh_in;
					end
				P_READ:
					if (byte_done)
					begin
						next_bcnt = '0;
						next_addr = addr + ADDR_BITS'(1);
						next_load_pend = 1'b1;
					end
				P_RESULT:
					if (byte_done)
					begin
						next_bcnt = '0;
						next_txbyte = (dly_cnt != '0) ? RES_BUSY : RES_OK; // [R4]
					end
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			pst <= P_IDLE;
			pend <= PD_NONE;
			bcnt <= '0;
			phase <= '0;
			shreg <= 8'h00;
			txbyte <= 8'hff;
			addr <= '0;
			dly_cnt <= '0;
			rd_mode <= 1'b0;
			selected <= 1'b0;
			resume_ok <= 1'b0;
			od <= 1'b0;
			load_pend <= 1'b0;
			mem_we_out <= 1'b0;
			mem_wdata_out <= 8'h00;
			clear_state_out <= 1'b1;
			clock_run_out <= 1'b0;
			busy_out <= 1'b0;
			overdrive_out <= 1'b0;
			selected_out <= 1'b0;
		end
		else
		begin
			pst <= next_pst;
			pend <= next_pend;
			bcnt <= next_bcnt;
			phase <= next_phase;
			shreg <= next_shreg;
			txbyte <= next_txbyte;
			addr <= next_addr;
			dly_cnt <= next_dly_cnt;
			rd_mode <= next_rd_mode;
			selected <= next_selected;
			resume_ok <= next_resume_ok;
			od <= next_od;
			load_pend <= next_load_pend;
			mem_we_out <= next_we;
			mem_wdata_out <= next_wdata;
			clear_state_out <= next_clear_state;
			clock_run_out <= next_clock_run;
			busy_out <= next_dly_cnt != '0;
			overdrive_out <= next_od;
			selected_out <= next_selected;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	property p_log_ro;
		mem_we_out |-> (mem_addr_out < LOG_BASE) && !in_rng(mem_addr_out, RO_BASE, RO_END);
	endproperty
	a_log_ro: assert property (p_log_ro) else $error("write reached read-only space"); // [R8]
	property p_mission_lock;
		mem_we_out && $past(mission_in) |-> !in_rng(mem_addr_out, REG_BASE, REG_END);
	endproperty
	a_mission_lock: assert property (p_mission_lock) else $error("register page written during mission"); // [R9]
	property p_we_selected;
		mem_we_out |-> selected && pst == P_WRITE;
	endproperty
	a_we_selected: assert property (p_we_selected) else $error("memory write without selection"); // [R13]
	property p_pw_hidden;
		load_pend && in_rng(addr[ADDR_W-1:0], PW_BASE, PW_END) |=> txbyte == PW_READ_VAL;
	endproperty
	a_pw_hidden: assert property (p_pw_hidden) else $error("password content read back"); // [R10]
	property p_release;
		io_oe_out && slot == SL_LOW |-> selected || pst == P_ROMREAD || pst == P_SEARCH;
	endproperty
	a_release: assert property (p_release) else $error("line driven while not addressed"); // [R18]
	property p_od_entry;
		$rose(od) |-> $past(pst == P_ROMCMD && bit_evt && byte_done);
	endproperty
	a_od_entry: assert property (p_od_entry) else $error("overdrive entered outside a selection byte"); // [R12]
	property p_od_exit;
		$fell(od) |-> $past(rst_evt && rst_long);
	endproperty
	a_od_exit: assert property (p_od_exit) else $error("overdrive left without long reset"); // [R17]
	property p_clear_bound;
		dly_cnt <= DLY_W'(LOG_CLEAR) && (pend != PD_CLOCK || dly_cnt <= DLY_W'(CLOCK_START));
	endproperty
	a_clear_bound: assert property (p_clear_bound) else $error("command delay exceeds its limit"); // [R4] [R5]
	property p_clear_entry;
		$rose(clear_state_out) |-> $past(pend == PD_CLEAR && dly_cnt == DLY_W'(1));
	endproperty
	a_clear_entry: assert property (p_clear_entry) else $error("clear state entered without log clear"); // [R16]
endmodule

// file: dv/lgr_master_model.sv
// bus master model driving the shared single-wire line
`timescale 1ns/100ps
module lgr_master_model (
	input wire logic clk_in,
	input wire logic dev_pull_in,
	output logic line_out
);
	logic pull = 1'b0;
	logic od = 1'b0;
	logic pres = 1'b0;

	// --------------------------------------------------------------
	// open-drain wire with pull-up
	// --------------------------------------------------------------
	// released line goes to the pull-up level, never keeps a stale value
	assign line_out = !(pull || dev_pull_in);

	task automatic hold(input logic low, input int cyc);
		pull <= low;
		repeat (cyc) @(posedge clk_in);
	endtask

	// --------------------------------------------------------------
	// slots
	// --------------------------------------------------------------
	task automatic line_reset(input logic std);
		if (std)
			od = 1'b0;
		hold(1'b1, od ? 2200 : 21000);
		hold(1'b0, od ? 700 : 3050);
		@(negedge clk_in);
		pres = !line_out;
		hold(1'b0, od ? 900 : 300);
	endtask

	task automatic put_bit(input logic b);
		hold(1'b1, b ? (od ? 50 : 600) : (od ? 700 : 7000));
		hold(1'b0, od ? 250 : 600);
	endtask

	task automatic get_bit(output logic b);
		hold(1'b1, od ? 30 : 600);
		hold(1'b0, od ? 120 : 500);
		@(negedge clk_in);
		b = line_out;
		hold(1'b0, od ? 400 : 3000);
	endtask

	task automatic send_byte(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
			put_bit(v[i]);
	endtask

	task automatic get_byte(output logic [7:0] v);
		for (int i = 0; i < 8; i++)
			get_bit(v[i]);
	endtask
endmodule

// file: dv/lgr_front_end_bench.sv
// self-checking bench for the single-wire front end
`timescale 1ns/100ps
module lgr_front_end_bench;
	import lgr_pkg::*;
	localparam int LCLR = 50;
	localparam int CSTART = 20;
	// arbitrary identity values
	localparam logic [7:0] FAM = 8'hc3;
	localparam logic [47:0] SER = 48'h0000_0000_00b4;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic mission_in = 1'b0;
	logic alarm_in = 1'b0;
	logic [7:0] mem_rdata_in;
	logic line, io_out, io_oe_out, mem_we_out, overdrive_out, selected_out;
	logic busy_out, clear_state_out, clock_run_out, busy_q;
	logic [ADDR_W-1:0] mem_addr_out;
	logic [ADDR_W-1:0] we_addr = '0;
	logic [7:0] mem_wdata_out, rd;
	logic [7:0] we_data = 8'h00;
	int err_total = 0;
	int checks_done = 0;
	int we_cnt = 0;
	int busy_run = 0;

	always #5 clk_in = ~clk_in;

	lgr_front_end #(.RST_STD(20000), .RST_OD(2000), .PLOW_STD(100), .LOG_CLEAR(LCLR),
		.CLOCK_START(CSTART), .FAMILY(FAM), .SERIAL(SER)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.io_in(line), .io_out(io_out), .io_oe_out(io_oe_out), .mission_in(mission_in), .alarm_in(alarm_in),
		.mem_rdata_in(mem_rdata_in), .mem_addr_out(mem_addr_out), .mem_we_out(mem_we_out),
		.mem_wdata_out(mem_wdata_out), .overdrive_out(overdrive_out), .selected_out(selected_out),
		.busy_out(busy_out), .clear_state_out(clear_state_out), .clock_run_out(clock_run_out));

	lgr_master_model u_mst (.clk_in(clk_in), .dev_pull_in(io_oe_out), .line_out(line));

	// --------------------------------------------------------------
	// memory side and monitors
	// --------------------------------------------------------------
	// read data pattern depends on address so a wrong address shows
	// answers at once: the read latch takes it the cycle after the address moves
	assign mem_rdata_in = mem_addr_out[7:0] ^ 8'h5c;

	always @(posedge clk_in)
	begin
		busy_q <= busy_out;
		if (busy_out === 1'b1)
			busy_run <= (busy_q === 1'b1) ? busy_run + 1 : 1;
		if (mem_we_out === 1'b1)
		begin
			we_cnt <= we_cnt + 1;
			we_addr <= mem_addr_out;
			we_data <= mem_wdata_out;
		end
	end

	task automatic chk_val(input logic [16:0] got, input logic [16:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_val({16'h0000, got}, {16'h0000, exp});
	endtask

	task automatic close_out();
		$display("mismatches %0d comparisons %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic t_idle();
		logic b;
		chk_bit(clear_state_out, 1'b1);
		chk_bit(overdrive_out, 1'b0);
		chk_bit(io_out, 1'b0);
		u_mst.get_bit(b);
		chk_bit(b, 1'b1);
		chk_bit(selected_out, 1'b0);
	endtask

	task automatic t_enter_od();
		u_mst.line_reset(1'b1);
		chk_bit(u_mst.pres, 1'b1);
		u_mst.send_byte(ROM_OD_SKIP);
		u_mst.od = 1'b1;
		chk_bit(overdrive_out, 1'b1);
		chk_bit(selected_out, 1'b1);
	endtask

	// last general byte then first register byte under a mission
	task automatic t_write_guard();
		mission_in <= 1'b1;
		u_mst.send_byte(FN_WRITE);
		u_mst.send_byte(8'hff);
		u_mst.send_byte(8'h01);
		u_mst.send_byte(8'h00);
		u_mst.send_byte(8'h1e);
		u_mst.send_byte(8'h33);
		mission_in <= 1'b0;
		chk_val(17'(we_cnt), 17'h00001);
		chk_val(we_addr, 17'h001ff);
		chk_val({9'h000, we_data}, 17'h0001e);
	endtask

	task automatic t_sel(input logic [7:0] fn);
		u_mst.line_reset(1'b0);
		chk_bit(u_mst.pres, 1'b1);
		u_mst.send_byte(ROM_SKIP);
		u_mst.send_byte(fn);
	endtask

	// read-only counter byte then a password byte
	task automatic t_pw_read();
		t_sel(FN_READ);
		u_mst.send_byte(8'h2f);
		u_mst.send_byte(8'h02);
		u_mst.send_byte(8'h00);
		u_mst.get_byte(rd);
		chk_val({9'h000, rd}, 17'h00073);
		u_mst.get_byte(rd);
		chk_val({9'h000, rd}, {9'h000, PW_READ_VAL});
		chk_val(17'(we_cnt), 17'h00001);
	endtask

	task automatic t_long_cmd(input logic [7:0] fn, input int lim);
		t_sel(fn);
		u_mst.get_byte(rd);
		chk_val({9'h000, rd}, {9'h000, RES_BUSY});
		u_mst.get_byte(rd);
		chk_val({9'h000, rd}, {9'h000, RES_OK});
		chk_bit(busy_out, 1'b0);
		chk_bit(busy_run >= 1 && busy_run <= lim, 1'b1);
	endtask

	task automatic t_rom_read();
		u_mst.line_reset(1'b0);
		u_mst.send_byte(ROM_READ);
		u_mst.get_byte(rd);
		chk_val({9'h000, rd}, {9'h000, FAM});
		u_mst.get_byte(rd);
		chk_val({9'h000, rd}, {9'h000, SER[7:0]});
	endtask

	// conditional search answers bit and complement only while the alarm is up
	task automatic t_cond(input logic alarm, input logic exp_cmp);
		logic b;
		alarm_in <= alarm;
		u_mst.line_reset(1'b0);
		u_mst.send_byte(ROM_COND);
		u_mst.get_bit(b);
		chk_bit(b, FAM[0]);
		u_mst.get_bit(b);
		chk_bit(b, exp_cmp);
		alarm_in <= 1'b0;
	endtask

	// --------------------------------------------------------------
	// main sequence and watchdog
	// --------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		t_idle();
		t_enter_od();
		t_write_guard();
		t_pw_read();
		t_long_cmd(FN_LOG_CLEAR, LCLR + 2);
		chk_bit(clear_state_out, 1'b1);
		t_long_cmd(FN_CLOCK_START, CSTART + 2);
		chk_bit(clock_run_out, 1'b1);
		chk_bit(clear_state_out, 1'b0);
		t_rom_read();
		t_cond(1'b1, ~FAM[0]);
		t_cond(1'b0, 1'b1);
		u_mst.line_reset(1'b1);
		chk_bit(overdrive_out, 1'b0);
		chk_bit(u_mst.pres, 1'b1);
		close_out();
	end

	// whole run needs about 250k cycles
	initial
	begin
		repeat (400000) @(posedge clk_in);
		err_total++;
		close_out();
	end
endmodule
